// File: rtl/pmw_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 40 MHz system clock and an 8-bit register address
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH

`define PMW_OFS_GRC       8'h26
`define PMW_OFS_WFC       8'h2A
`define PMW_OFS_IEM       8'h90
`define PMW_OFS_ISF       8'h92
`define PMW_OFS_SWT       8'h8E
`define PMW_OFS_PSC       8'hF4
`define PMW_OFS_PMEC      8'hD4

`define PMW_MODE_NORMAL   2'h0
`define PMW_MODE_EDET     2'h1
`define PMW_MODE_PSAVE    2'h3

`define PMW_PMEC_AUTOWAKE 7
`define PMW_PMEC_TONORMAL 6
`define PMW_PMEC_EVT_LO   8
`define PMW_PSC_PSAVE     10
`define PMW_WFC_MAGIC     7
`define PMW_EVT_ENERGY    2
`define PMW_EVT_LINK      3
`define PMW_EVT_MAGIC     4
`define PMW_EVT_FRAME     5

`define PMW_RST_REG       16'h0000
`define PMW_CLK_NS        25
`define PMW_UNIT_NS       1000
`define PMW_UNIT_CYC      ((`PMW_UNIT_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)

`endif

// File: rtl/pmw_pkg.sv
// types shared by the power and wake control block
// assumes nothing beyond a SystemVerilog tool
package pmw_pkg;

    typedef enum logic [1:0]
    {
        PMW_ST_NORMAL,
        PMW_ST_LOW,
        PMW_ST_PSAVE
    } pmw_state_t;

endpackage : pmw_pkg

// File: rtl/pmw_power_wake.sv
// power mode selection, energy timing and wake event reporting
// assumes energy, link and frame-match inputs synchronous to mclk
//
// Functional notes
// - mode field picks normal, energy-detect, power-saving
// - mode field resets to normal
// - normal mode: clocks, PHY, MAC, host on
// - power saving needs autoneg, no cable, bits
// - power saving keeps clocks, MAC, host, registers
// - line activity restores PHY receive power
// - no energy past go-sleep time: low power
// - low power disables all but energy detector
// - energy past wake time wakes if auto-wake
// - auto-wake plus bit 6 returns normal mode
// - energy event drives power event if enabled
// - energy event raises interrupt if enabled
// - global reset register read wakes device
// - wake frame signals by interrupt or event
// - energy event recorded in status bit 2
// - link-up recorded in status bit 3
// - remote wake pattern in status bit 4
// - wake-up frame recorded in status bit 5
// - pattern scanning only while enable bit set
`timescale 1ns/1ps
`include "pmw_defs.svh"

module pmw_power_wake
#(
    parameter int TICK_CYC = `PMW_UNIT_CYC
)
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_ack,
    // line and frame status
    input  wire logic        autoneg_en,
    input  wire logic        cable_present,
    input  wire logic        energy_present,
    input  wire logic        link_up_evt,
    input  wire logic        magic_match,
    input  wire logic [3:0]  wake_frame_hit,
    // power controls
    output logic             pll_en,
    output logic             mac_en,
    output logic             host_if_en,
    output logic             phy_tx_en,
    output logic             phy_rx_en,
    output logic             edet_only,
    // wake signalling
    output logic             power_event_out,
    output logic             host_irq_n
);

    localparam logic [15:0] RST_REG = `PMW_RST_REG;

    function automatic logic [8:0] sat_inc(input logic [8:0] v);
        sat_inc = (v == 9'h1FF) ? v : v + 9'h001;
    endfunction : sat_inc

    pmw_pkg::pmw_state_t state_q;
    logic [15:0] global_reset_control_q;
    logic [15:0] wake_frame_control_q;
    logic [15:0] interrupt_enable_mask_q;
    logic [15:0] interrupt_status_flags_q;
    logic [15:0] sleep_wake_timing_q;
    logic [15:0] phy_special_control_q;
    logic [15:0] power_event_control_q;
    logic [15:0] tick_cnt_q;
    logic        tick;
    logic [8:0]  quiet_cnt_q;
    logic [8:0]  busy_cnt_q;
    logic        host_ok;
    logic        wr_ok;
    logic [1:0]  mode;
    logic        psave_eff;
    logic        gosleep;
    logic        wake_due;
    logic        energy_evt;
    logic        rd_wake;
    logic [15:0] evt_set;
    logic [15:0] flag_clr;
    logic [3:0]  evt_out_en;

    assign mode      = power_event_control_q[1:0];
    assign host_ok   = state_q != pmw_pkg::PMW_ST_LOW;
    assign wr_ok     = reg_wr && host_ok;
    assign psave_eff = autoneg_en && !cable_present &&
                       mode == `PMW_MODE_PSAVE &&
                       phy_special_control_q[`PMW_PSC_PSAVE];
    assign gosleep   = quiet_cnt_q > {1'b0, sleep_wake_timing_q[7:0]};
    assign wake_due  = busy_cnt_q > {1'b0, sleep_wake_timing_q[15:8]};
    // one event per sustained burst: fires as the count first passes
    assign energy_evt = state_q == pmw_pkg::PMW_ST_LOW && wake_due &&
                        busy_cnt_q == {1'b0, sleep_wake_timing_q[15:8]}
                        + 9'h001;
    // the wake read is decoded even with the host interface off
    assign rd_wake   = reg_rd && reg_addr == `PMW_OFS_GRC;
    assign evt_out_en = power_event_control_q[`PMW_PMEC_EVT_LO +: 4];

    // slow timebase for the sleep and wake windows
    always_ff @(posedge mclk)
    begin
        if (srst || tick_cnt_q == 16'(TICK_CYC - 1))
            tick_cnt_q <= 16'h0000;
        else
            tick_cnt_q <= tick_cnt_q + 16'h0001;
    end

    assign tick = tick_cnt_q == 16'(TICK_CYC - 1);

    // energy absence and presence windows
    always_ff @(posedge mclk)
    begin
        if (srst || mode != `PMW_MODE_EDET || energy_present)
            quiet_cnt_q <= 9'h000;
        else if (tick)
            quiet_cnt_q <= sat_inc(quiet_cnt_q);
    end

    always_ff @(posedge mclk)
    begin
        if (srst || state_q != pmw_pkg::PMW_ST_LOW || !energy_present)
            busy_cnt_q <= 9'h000;
        else if (tick)
            busy_cnt_q <= sat_inc(busy_cnt_q);
    end

    // power state sequencing
    always_ff @(posedge mclk)
    begin
        if (srst)
            state_q <= pmw_pkg::PMW_ST_NORMAL;
        else
        begin
            case (state_q)
                pmw_pkg::PMW_ST_NORMAL:
                    if (psave_eff)
                        state_q <= pmw_pkg::PMW_ST_PSAVE;
                    else if (mode == `PMW_MODE_EDET && gosleep)
                        state_q <= pmw_pkg::PMW_ST_LOW;
                pmw_pkg::PMW_ST_LOW:
                    if (rd_wake)
                        state_q <= pmw_pkg::PMW_ST_NORMAL;
                    else if (wake_due &&
                             power_event_control_q[`PMW_PMEC_AUTOWAKE])
                        state_q <= pmw_pkg::PMW_ST_NORMAL;
                pmw_pkg::PMW_ST_PSAVE:
                    if (!psave_eff)
                        state_q <= pmw_pkg::PMW_ST_NORMAL;
                default:
                    state_q <= pmw_pkg::PMW_ST_NORMAL;
            endcase
        end
    end

    // power controls, one flop each
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pll_en     <= 1'b1;
            mac_en     <= 1'b1;
            host_if_en <= 1'b1;
            phy_tx_en  <= 1'b1;
            phy_rx_en  <= 1'b1;
            edet_only  <= 1'b0;
        end
        else
        begin
            pll_en     <= state_q != pmw_pkg::PMW_ST_LOW;
            mac_en     <= state_q != pmw_pkg::PMW_ST_LOW;
            host_if_en <= host_ok;
            phy_tx_en  <= state_q != pmw_pkg::PMW_ST_LOW;
            // receive in power saving is on only while the line shows energy
            phy_rx_en  <= state_q == pmw_pkg::PMW_ST_NORMAL ||
                          (state_q == pmw_pkg::PMW_ST_PSAVE &&
                           energy_present);
            edet_only  <= state_q == pmw_pkg::PMW_ST_LOW;
        end
    end

    // power event control, mode field and enables
    always_ff @(posedge mclk)
    begin
        if (srst)
            power_event_control_q <= RST_REG;
        else if (state_q == pmw_pkg::PMW_ST_LOW && wake_due &&
                 power_event_control_q[`PMW_PMEC_AUTOWAKE] &&
                 power_event_control_q[`PMW_PMEC_TONORMAL])
            power_event_control_q[1:0] <= `PMW_MODE_NORMAL;
        else if (wr_ok && reg_addr == `PMW_OFS_PMEC)
            power_event_control_q <= reg_wdata;
    end

    // plain storage registers
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            global_reset_control_q  <= RST_REG;
            wake_frame_control_q    <= RST_REG;
            interrupt_enable_mask_q <= RST_REG;
            sleep_wake_timing_q     <= RST_REG;
            phy_special_control_q   <= RST_REG;
        end
        else if (wr_ok)
        begin
            case (reg_addr)
                `PMW_OFS_GRC: global_reset_control_q  <= reg_wdata;
                `PMW_OFS_WFC: wake_frame_control_q    <= reg_wdata;
                `PMW_OFS_IEM: interrupt_enable_mask_q <= reg_wdata;
                `PMW_OFS_SWT: sleep_wake_timing_q     <= reg_wdata;
                `PMW_OFS_PSC: phy_special_control_q   <= reg_wdata;
                default: ;
            endcase
        end
    end

    // wake events into sticky status
    always_comb
    begin
        evt_set                  = 16'h0000;
        evt_set[`PMW_EVT_ENERGY] = energy_evt;
        evt_set[`PMW_EVT_LINK]   = link_up_evt;
        evt_set[`PMW_EVT_MAGIC]  = magic_match &&
                                   wake_frame_control_q[`PMW_WFC_MAGIC];
        evt_set[`PMW_EVT_FRAME]  = |(wake_frame_hit &
                                     wake_frame_control_q[3:0]);
    end

    assign flag_clr = (wr_ok && reg_addr == `PMW_OFS_ISF) ?
                     reg_wdata : 16'h0000;

    // write one to clear; a fresh event beats the clear
    always_ff @(posedge mclk)
    begin
        if (srst)
            interrupt_status_flags_q <= RST_REG;
        else
            interrupt_status_flags_q <= (interrupt_status_flags_q &
                                         ~flag_clr) | evt_set;
    end
    // a pattern hit only counts while its scan enable is set

    // wake signalling outputs
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            host_irq_n      <= 1'b1;
            power_event_out <= 1'b0;
        end
        else
        begin
            host_irq_n      <= ~|(interrupt_status_flags_q &
                                  interrupt_enable_mask_q);
            power_event_out <= |(interrupt_status_flags_q[5:2] &
                                 evt_out_en);
        end
    end
    // frame wakes reach either output by its own enable

    // register read path; dark while in low power except the wake read
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            reg_rdata <= 16'h0000;
            reg_ack   <= 1'b0;
        end
        else
        begin
            reg_ack   <= (reg_rd || reg_wr) && (host_ok || rd_wake);
            reg_rdata <= 16'h0000;
            if (reg_rd && (host_ok || rd_wake))
            begin
                case (reg_addr)
                    `PMW_OFS_GRC:  reg_rdata <= global_reset_control_q;
                    `PMW_OFS_WFC:  reg_rdata <= wake_frame_control_q;
                    `PMW_OFS_IEM:  reg_rdata <= interrupt_enable_mask_q;
                    `PMW_OFS_ISF:  reg_rdata <= interrupt_status_flags_q;
                    `PMW_OFS_SWT:  reg_rdata <= sleep_wake_timing_q;
                    `PMW_OFS_PSC:  reg_rdata <= phy_special_control_q;
                    `PMW_OFS_PMEC: reg_rdata <= power_event_control_q;
                    default:       reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule : pmw_power_wake

// File: bench/pmw_checker.sv
// port assertions for the power and wake block
// assumes a bind into pmw_power_wake, one mclk domain
`timescale 1ns/1ps
module pmw_checker (
    // clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // register port and line
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_ack,
    input wire logic        energy_present,
    input wire logic        cable_present,
    // power and wake outputs
    input wire logic        pll_en,
    input wire logic        mac_en,
    input wire logic        host_if_en,
    input wire logic        phy_tx_en,
    input wire logic        phy_rx_en,
    input wire logic        edet_only,
    input wire logic        power_event_out,
    input wire logic        host_irq_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic psv;
    assign psv = pll_en & !phy_rx_en;
    ack_cause_a: assert property (reg_ack |-> $past(reg_wr | reg_rd))
        else $error("ack without strobe");
    reset_up_a: assert property ($fell(srst) |-> pll_en && phy_rx_en)
        else $error("not up after reset");
    low_off_a: assert property (edet_only |->
        !(pll_en | mac_en | host_if_en | phy_tx_en | phy_rx_en))
        else $error("block on in low power");
    run_on_a: assert property (pll_en |->
        mac_en && host_if_en && phy_tx_en)
        else $error("part off while clock runs");
    rx_wake_a: assert property (psv |-> !$past(energy_present))
        else $error("receiver off with energy");
    psave_cable_a: assert property (psv |->
        !($past(cable_present) && $past(cable_present, 2)))
        else $error("power saving with cable");
    // edet_only lags the state by one edge, so look one edge after the write
    refuse_low_a: assert property (reg_wr && !reg_rd ##1 edet_only |->
        !reg_ack)
        else $error("write taken in low power");
    wake_read_a: assert property (edet_only && reg_rd &&
        reg_addr == 8'h26 |=> reg_ack ##[0:2] !edet_only)
        else $error("wake read ignored");
    evt_hold_a: assert property ($fell(power_event_out) |->
        $past(reg_wr) || $past(reg_wr, 2))
        else $error("event output dropped alone");
    irq_hold_a: assert property ($rose(host_irq_n) |->
        $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt dropped alone");
    cover property ($rose(edet_only));
    cover property ($rose(power_event_out));
    cover property ($fell(host_irq_n));
    cover property (psv);
endmodule : pmw_checker

bind pmw_power_wake pmw_checker chk_i (.mclk, .srst, .reg_addr, .reg_wr,
    .reg_rd, .reg_ack, .energy_present, .cable_present, .pll_en, .mac_en,
    .host_if_en, .phy_tx_en, .phy_rx_en, .edet_only, .power_event_out,
    .host_irq_n);

// File: bench/pmw_host_model.sv
// host processor model issuing single register cycles
// assumes strobes taken on rising mclk, ack one cycle later
`timescale 1ns/1ps
module pmw_host_model (
    // clock
    input  wire logic        mclk,
    // register port
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_ack,
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    task automatic access(input logic w, input logic [7:0] a,
        input logic [15:0] d, output logic ack, output logic [15:0] q);
        @(negedge mclk);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        ack = reg_ack;
        q = reg_rdata;
        // released lines must not keep the last value
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : access
    task automatic wake(output logic ack);
        logic [15:0] q;
        access(1'b0, 8'h26, 16'h0000, ack, q);
    endtask : wake
    task automatic leave_psave;
        logic a;
        logic [15:0] q;
        access(1'b1, 8'hD4, 16'h0000, a, q);
        access(1'b1, 8'hF4, 16'h0000, a, q);
    endtask : leave_psave
endmodule : pmw_host_model

// File: bench/power_mgmt_wake_control_bench.sv
// self-checking bench for the power and wake block
// assumes pmw_host_model drives the register port, tick of 2 cycles
`timescale 1ns/1ps
module power_mgmt_wake_control_bench;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q;
    logic        reg_wr, reg_rd, reg_ack, ak;
    logic        autoneg_en = 1'b0, cable_present = 1'b1;
    logic        energy_present = 1'b1, link_up_evt = 1'b0;
    logic        magic_match = 1'b0;
    logic [3:0]  wake_frame_hit = 4'h0;
    logic        pll_en, mac_en, host_if_en, phy_tx_en, phy_rx_en;
    logic        edet_only, power_event_out, host_irq_n;
    int          bad_count = 0, n_checks = 0, cyc = 0;
    always #12.5 mclk = ~mclk;
    pmw_power_wake #(.TICK_CYC(2)) uut (.mclk, .srst, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .reg_ack, .autoneg_en,
        .cable_present, .energy_present, .link_up_evt, .magic_match,
        .wake_frame_hit, .pll_en, .mac_en, .host_if_en, .phy_tx_en,
        .phy_rx_en, .edet_only, .power_event_out, .host_irq_n);
    pmw_host_model host (.mclk, .reg_rdata, .reg_ack, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata);
    task automatic complete_run;
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.access(1'b1, a, d, ak, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        host.access(1'b0, a, 16'h0000, ak, q);
        chk(ak, 1'b1);
        chk(q, e);
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask : wt
    // one-cycle pulse on {frame hits, pattern, link}
    task automatic ev(input logic [5:0] v);
        @(negedge mclk);
        {wake_frame_hit, magic_match, link_up_evt} = v;
        @(negedge mclk);
        {wake_frame_hit, magic_match, link_up_evt} = 6'h00;
    endtask : ev
    task automatic t_reset;
        chk({pll_en, mac_en, host_if_en, phy_tx_en, phy_rx_en}, 16'h1F);
        rd(8'hD4, 16'h0000);
        rd(8'h00, 16'h0000);
        wr(8'h8E, 16'h0302);
        rd(8'h8E, 16'h0302);
    endtask : t_reset
    task automatic t_events;
        wr(8'h90, 16'h003C);
        ev(6'h02);
        rd(8'h92, 16'h0000);
        wr(8'h2A, 16'h0081);
        ev(6'h01);
        ev(6'h02);
        ev(6'h08);
        rd(8'h92, 16'h0018);
        ev(6'h04);
        rd(8'h92, 16'h0038);
        chk({power_event_out, host_irq_n}, 16'h0000);
        wr(8'hD4, 16'h0800);
        wt(2);
        chk(power_event_out, 1'b1);
        wr(8'h92, 16'h0038);
        wt(2);
        chk({power_event_out, host_irq_n}, 16'h0001);
    endtask : t_events
    task automatic t_edet;
        wr(8'h90, 16'h0004);
        wr(8'hD4, 16'h0101);
        energy_present = 1'b0;
        wt(3);
        chk(edet_only, 1'b0);
        wt(20);
        chk({edet_only, pll_en}, 16'h0002);
        wr(8'h8E, 16'h00FF);
        chk(ak, 1'b0);
        energy_present = 1'b1;
        wt(20);
        chk({edet_only, power_event_out, host_irq_n}, 16'h6);
        host.wake(ak);
        chk(ak, 1'b1);
        wt(2);
        chk(edet_only, 1'b0);
        rd(8'h92, 16'h0004);
        rd(8'h8E, 16'h0302);
        wr(8'h92, 16'h0004);
        wr(8'hD4, 16'h00C1);
        energy_present = 1'b0;
        wt(20);
        chk(edet_only, 1'b1);
        energy_present = 1'b1;
        wt(20);
        chk(edet_only, 1'b0);
        rd(8'hD4, 16'h00C0);
        wr(8'h92, 16'h0004);
    endtask : t_edet
    task automatic t_psave;
        energy_present = 1'b0;
        autoneg_en = 1'b1;
        cable_present = 1'b0;
        wr(8'hD4, 16'h0003);
        wt(2);
        chk(phy_rx_en, 1'b1);
        wr(8'hF4, 16'h0400);
        wt(2);
        chk({pll_en, mac_en, host_if_en, phy_tx_en, phy_rx_en}, 16'h1E);
        rd(8'h8E, 16'h0302);
        energy_present = 1'b1;
        wt(2);
        chk(phy_rx_en, 1'b1);
        energy_present = 1'b0;
        cable_present = 1'b1;
        wt(2);
        chk(phy_rx_en, 1'b1);
        cable_present = 1'b0;
        wt(2);
        chk(phy_rx_en, 1'b0);
        host.leave_psave();
        wt(2);
        chk(phy_rx_en, 1'b1);
        rd(8'hD4, 16'h0000);
    endtask : t_psave
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            complete_run();
        end
    end
    initial
    begin
        wt(20);
        srst = 1'b0;
        t_reset();
        t_events();
        t_edet();
        t_psave();
        complete_run();
    end
endmodule : power_mgmt_wake_control_bench
